/* File: core/table_read_data_memory.sv */
// program-memory table read path plus two-bank 8-bit data memory
`timescale 1ns/1ps
// How it works
// - current-page table address is page base joined with pointer low byte
// - a table read loads the upper program word bits into the high latch
// - high latch is readable, writes to it are ignored
// - table read takes exactly two cycles, busy in the second
// - program memory is 1K words; last page starts at 300H
// - each data memory location is 8 bits wide
// - two banks; special area shared except eeprom control at 40H, bank 1 only
// - bank chosen by the bank selector register value
// - addressing starts at 00H, special area below general purpose area
// - unimplemented special locations read 00H and hold nothing
// - general purpose bytes read, written and bit set/cleared
// - read-only special registers ignore writes
// - programmer loads program words serially; here a word write port stands in
// - low byte of the table word goes to a general purpose or pointer operand; the bank selector keeps only its bit 0
// - latch bits beyond the program word width read as zero
// - bank select bit 0 picks the bank, resets to 0
module table_read_data_memory
  import tbl_mem_pkg::*;
#(
  parameter int unsigned GP_DEPTH = 160
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire mem_req_t req,
  output logic busy,
  output logic [7:0] rdata,
  output logic [1:0] state_dbg,
  input wire prog_wr_t prog_wr,
  output logic [7:0] eeprom_control_reg,
  output logic [7:0] data_bank_selector
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FETCH = 2'b01,
    S_DONE = 2'b10
  } tbl_state_t;

  logic [PROG_DW-1:0] prog_mem [PROG_WORDS];
  logic [7:0] gp_bank0 [GP_DEPTH];
  logic [7:0] gp_bank1 [GP_DEPTH];

  tbl_state_t state_q;
  tbl_state_t state_d;
  logic [7:0] bank_q;
  logic [7:0] tbl_ptr_q;
  logic [7:0] tbl_high_q;
  logic [7:0] eec_q;
  logic [7:0] page_hi_q;
  logic [7:0] rd_mux;
  logic [7:0] dest_q;
  logic [PROG_DW-1:0] word_q;
  logic [7:0] rdata_q;

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (a >= GP_START) && ((a - GP_START) < 8'(GP_DEPTH));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire logic bank_sel = bank_q[BANK_BIT_POS];
  wire logic [9:0] tbl_addr = {page_hi_q[1:0], tbl_ptr_q};
  wire logic req_gp = is_gp(req.addr);
  wire logic dest_gp = is_gp(dest_q);
  wire logic [7:0] gp_idx = req.addr - GP_START;
  wire logic [7:0] dest_idx = dest_q - GP_START;
  wire logic eec_hit = (req.addr == EEC_ADDR) && bank_sel;
  wire logic [7:0] gp_rd = bank_sel ? gp_bank1[gp_idx] : gp_bank0[gp_idx];
  wire logic [7:0] tbl_high_rd = {{(16 - PROG_DW){1'b0}}, word_q[PROG_DW-1:8]};
  wire logic issue = clk_en && (state_q == S_IDLE);
  wire logic do_wr = issue && (req.op == OP_WRITE);
  wire logic do_bit = issue && (req.op == OP_BIT);
  wire logic do_tab = issue && (req.op == OP_TABRD);
  wire logic [7:0] bit_mask = 8'h01 << req.bit_idx;
  wire logic [7:0] cur_val = req_gp ? gp_rd : rd_mux;
  wire logic [7:0] bit_new = req.bit_val ? (cur_val | bit_mask) : (cur_val & ~bit_mask);
  wire logic [7:0] wr_val = do_bit ? bit_new : req.wdata;
  wire logic wr_any = do_wr || do_bit;
  wire logic hit_bank = (req.addr == BANK_SEL_ADDR);
  wire logic hit_ptr = (req.addr == TBL_PTR_ADDR);
  wire logic hit_high = (req.addr == TBL_HIGH_ADDR);
  wire logic hit_page = (req.addr == PAGE_HI_ADDR);
  wire logic fetch = clk_en && (state_q == S_FETCH);
  wire logic wr_sfr = wr_any && !req_gp;
  wire logic wr_bank = wr_sfr && hit_bank;
  wire logic wr_ptr = wr_sfr && hit_ptr;
  wire logic wr_page = wr_sfr && hit_page;
  wire logic wr_eec = wr_sfr && eec_hit;
  wire logic fetch_bank = fetch && (dest_q == BANK_SEL_ADDR);
  wire logic fetch_ptr = fetch && (dest_q == TBL_PTR_ADDR);

  always_comb begin
    rd_mux = 8'h00;
    if (req_gp) begin
      rd_mux = gp_rd;
    end else if (hit_bank) begin
      rd_mux = bank_q;
    end else if (hit_ptr) begin
      rd_mux = tbl_ptr_q;
    end else if (hit_high) begin
      rd_mux = tbl_high_q;
    end else if (hit_page) begin
      rd_mux = page_hi_q;
    end else if (eec_hit) begin
      rd_mux = eec_q;
    end
  end

  always_comb begin
    case (state_q)
      S_IDLE: state_d = do_tab ? S_FETCH : S_IDLE;
      S_FETCH: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  assign busy = (state_q == S_FETCH);
  assign rdata = rdata_q;
  assign state_dbg = state_q;
  assign eeprom_control_reg = eec_q;
  assign data_bank_selector = bank_q;

  ////////////////////////////////////////////////////////////////////////
  // control registers, one short process each; the table destination and word share one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // captured for every issued op, so a read never waits on the table path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (issue) begin
      rdata_q <= rd_mux;
    end
  end

  // only the select bit is kept; a table read may land here as well
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bank_q <= BANK_SEL_RST;
    end else if (wr_bank) begin
      bank_q <= {7'h00, wr_val[BANK_BIT_POS]};
    end else if (fetch_bank) begin
      bank_q <= {7'h00, word_q[BANK_BIT_POS]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_ptr_q <= TBL_PTR_RST;
    end else if (wr_ptr) begin
      tbl_ptr_q <= wr_val;
    end else if (fetch_ptr) begin
      tbl_ptr_q <= word_q[7:0];
    end
  end

  // two page bits exist; reset points the table at the last page
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_hi_q <= {6'h00, LAST_PAGE_BASE[9:8]};
    end else if (wr_page) begin
      page_hi_q <= {6'h00, wr_val[1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eec_q <= EEC_RST;
    end else if (wr_eec) begin
      eec_q <= wr_val;
    end
  end

  // no write path: a lost latch value cannot be put back by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_high_q <= TBL_HIGH_RST;
    end else if (fetch) begin
      tbl_high_q <= tbl_high_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dest_q <= 8'h00;
      word_q <= '0;
    end else if (do_tab) begin
      dest_q <= req.addr;
      word_q <= prog_mem[tbl_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memories, no reset so they map onto ram
  always_ff @(posedge clk) begin
    if (clk_en && wr_any && req_gp) begin
      if (bank_sel) begin
        gp_bank1[gp_idx] <= wr_val;
      end else begin
        gp_bank0[gp_idx] <= wr_val;
      end
    end else if (clk_en && state_q == S_FETCH && dest_gp) begin
      if (bank_sel) begin
        gp_bank1[dest_idx] <= word_q[7:0];
      end else begin
        gp_bank0[dest_idx] <= word_q[7:0];
      end
    end
  end

  // serial loader reduced to a word port; serial framing is outside this block
  always_ff @(posedge clk) begin
    if (clk_en && prog_wr.we) begin
      prog_mem[prog_wr.addr] <= prog_wr.wdata;
    end
  end

endmodule

/* File: core/tbl_mem_pkg.sv */
// shared constants and carrier types for the table-read and data memory block
package tbl_mem_pkg;
  localparam int unsigned PROG_WORDS = 1024;
  localparam int unsigned PROG_AW = 10;
  localparam int unsigned PROG_DW = 14;
  localparam logic [9:0] LAST_PAGE_BASE = 10'h300;
  localparam logic [7:0] DATA_BASE = 8'h00;
  localparam logic [7:0] GP_START = 8'h60;
  localparam logic [7:0] EEC_ADDR = 8'h40;
  localparam logic [7:0] BANK_SEL_ADDR = 8'h04;
  localparam logic [7:0] TBL_PTR_ADDR = 8'h07;
  localparam logic [7:0] TBL_HIGH_ADDR = 8'h08;
  localparam logic [7:0] PAGE_HI_ADDR = 8'h09;
  localparam logic [7:0] BANK_SEL_RST = 8'h00;
  localparam logic [7:0] TBL_PTR_RST = 8'h00;
  localparam logic [7:0] TBL_HIGH_RST = 8'h00;
  localparam logic [7:0] EEC_RST = 8'h00;
  localparam int unsigned TBL_CYCLES = 2;
  localparam int unsigned BANK_BIT_POS = 0;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WRITE = 2'b01,
    OP_BIT = 2'b10,
    OP_TABRD = 2'b11
  } mem_op_t;

  typedef struct packed {
    mem_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
    logic bit_val;
  } mem_req_t;

  typedef struct packed {
    logic [9:0] addr;
    logic we;
    logic [13:0] wdata;
  } prog_wr_t;
endpackage

/* File: dv/tbl_mem_asserts.sv */
// port checks for the table read and data memory block
`timescale 1ns/1ps
module tbl_mem_asserts
  import tbl_mem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire mem_req_t req,
  input wire logic busy,
  input wire logic [7:0] rdata,
  input wire logic [1:0] state_dbg,
  input wire prog_wr_t prog_wr,
  input wire logic [7:0] eeprom_control_reg,
  input wire logic [7:0] data_bank_selector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence take_s(mem_op_t o, logic [7:0] a);
    clk_en && !busy && req.op == o && req.addr == a;
  endsequence
  sequence tab_take_s;
    clk_en && !busy && req.op == OP_TABRD;
  endsequence
  sequence eec_try_s;
    clk_en && busy && req.op == OP_WRITE && req.addr == EEC_ADDR;
  endsequence
  tab_refuse_a: assert property (tab_take_s ##1 eec_try_s |=>
    $stable(eeprom_control_reg)) else $error("write taken during table read");
  freeze_hold_a: assert property (!clk_en |=>
    $stable(data_bank_selector) && $stable(rdata))
    else $error("state moved while enable low");
  tab_busy_a: assert property (clk_en && !busy && req.op == OP_TABRD |=> busy)
    else $error("table read without busy");
  busy_once_a: assert property (busy && clk_en |=> !busy)
    else $error("busy longer than one cycle");
  busy_state_a: assert property (busy == (state_dbg == 2'd1))
    else $error("busy and fetch state disagree");
  bank_pad_a: assert property (data_bank_selector[7:1] == 7'h00)
    else $error("bank selector upper bits set");
  bank_wr_a: assert property (take_s(OP_WRITE, BANK_SEL_ADDR) |=>
    data_bank_selector == {7'h00, $past(req.wdata[0])}) else $error("bank write lost");
  eec_b0_a: assert property (take_s(OP_WRITE, EEC_ADDR) ##0 !data_bank_selector[0] |=>
    $stable(eeprom_control_reg)) else $error("eeprom control written in bank 0");
  eec_b1_a: assert property (take_s(OP_WRITE, EEC_ADDR) ##0 data_bank_selector[0] |=>
    eeprom_control_reg == $past(req.wdata)) else $error("eeprom control write lost");
  unimp_zero_a: assert property (take_s(OP_NONE, 8'h10) |=> rdata == 8'h00)
    else $error("unimplemented location not zero");
endmodule
bind table_read_data_memory tbl_mem_asserts tbl_mem_asserts_inst (
  .clk(clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .req(req),
  .busy(busy),
  .rdata(rdata),
  .state_dbg(state_dbg),
  .prog_wr(prog_wr),
  .eeprom_control_reg(eeprom_control_reg),
  .data_bank_selector(data_bank_selector)
);

/* File: dv/prog_loader.sv */
// programmer side: loads eight words into the last program page
`timescale 1ns/1ps
module prog_loader
  import tbl_mem_pkg::*;
(
  input wire logic clk,
  output prog_wr_t prog_wr,
  output logic done
);
  initial begin
    prog_wr = '0;
    done = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      prog_wr <= {LAST_PAGE_BASE + 10'(i), 1'b1, 14'(i) * 14'h0111 + 14'h2aa5};
    end
    @(negedge clk);
    // released: inverted leftovers so stale data never looks valid
    prog_wr <= {~prog_wr.addr, 1'b0, ~prog_wr.wdata};
    done <= 1'b1;
  end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the table read and data memory block
`timescale 1ns/1ps
module testbench;
  import tbl_mem_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  mem_req_t req = '0;
  prog_wr_t prog_wr;
  logic busy;
  logic done;
  logic [7:0] rdata;
  logic [7:0] eec;
  logic [7:0] bank;
  int error_cnt = 0;
  int checked = 0;
  table_read_data_memory table_read_data_memory_inst (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .req(req), .busy(busy), .rdata(rdata), .state_dbg(), .prog_wr(prog_wr),
    .eeprom_control_reg(eec), .data_bank_selector(bank));
  prog_loader prog_loader_inst (.clk(clk), .prog_wr(prog_wr), .done(done));
  initial forever #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic go(mem_op_t o, logic [7:0] a, logic [7:0] d = 8'h00, logic [2:0] b = 3'd0,
      logic v = 1'b0);
    @(negedge clk);
    req <= {o, a, d, b, v};
    @(negedge clk);
    req.op <= OP_NONE;
  endtask
  task automatic rd(string n, logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    req <= {OP_NONE, a, 12'h000};
    @(negedge clk);
    cmp(n, e, rdata);
  endtask
  // word at page offset p as the loader wrote it
  task automatic tab(logic [7:0] p, logic [7:0] dst);
    logic [13:0] x;
    x = 14'(p) * 14'h0111 + 14'h2aa5;
    go(OP_WRITE, TBL_PTR_ADDR, p);
    go(OP_TABRD, dst);
    cmp("busy", 8'h01, {7'h00, busy});
    rd("low", dst, x[7:0]);
    rd("high", TBL_HIGH_ADDR, {2'b00, x[13:8]});
  endtask
  // s_table and s_bank both issue table reads; each latch check comes before the next read
  task automatic s_table;
    tab(8'h06, 8'h60);
    tab(8'h05, 8'h61);
    go(OP_WRITE, TBL_HIGH_ADDR, 8'hff);
    rd("ro", TBL_HIGH_ADDR, 8'h2f);
    rd("dst", 8'h60, 8'h0b);
    tab(8'h07, TBL_PTR_ADDR);
  endtask
  task automatic s_bank;
    go(OP_WRITE, 8'h70, 8'h11);
    go(OP_WRITE, BANK_SEL_ADDR, 8'h01);
    go(OP_WRITE, 8'h70, 8'h22);
    go(OP_BIT, 8'h70, 8'h00, 3'd7, 1'b1);
    go(OP_WRITE, EEC_ADDR, 8'h5a);
    rd("gp1", 8'h70, 8'ha2);
    rd("eec1", EEC_ADDR, 8'h5a);
    go(OP_WRITE, TBL_PTR_ADDR, 8'h00);
    // table read into bank 1, with a write offered in its busy cycle
    @(negedge clk);
    req <= {OP_TABRD, 8'h62, 8'h00, 3'h0, 1'b0};
    @(negedge clk);
    req <= {OP_WRITE, EEC_ADDR, 8'h77, 3'h0, 1'b0};
    @(negedge clk);
    req.op <= OP_NONE;
    rd("eec busy", EEC_ADDR, 8'h5a);
    rd("b1 dst", 8'h62, 8'ha5);
    go(OP_WRITE, BANK_SEL_ADDR, 8'h00);
    go(OP_WRITE, EEC_ADDR, 8'h00);
    rd("gp0", 8'h70, 8'h11);
    rd("eec0", EEC_ADDR, 8'h00);
    cmp("eec", 8'h5a, eec);
    go(OP_BIT, 8'h70, 8'h00, 3'd0, 1'b0);
    rd("gp0 clr", 8'h70, 8'h10);
    go(OP_WRITE, 8'h10, 8'hff);
    rd("unimp", 8'h10, 8'h00);
  endtask
  // enable low: an offered bank write must not land
  task automatic s_freeze;
    @(negedge clk);
    clk_en <= 1'b0;
    req <= {OP_WRITE, BANK_SEL_ADDR, 8'h01, 3'h0, 1'b0};
    repeat (2) @(negedge clk);
    cmp("bank frozen", 8'h00, bank);
    clk_en <= 1'b1;
    req.op <= OP_NONE;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) @(negedge clk);
    if (!done) begin
      error_cnt++;
    end else begin
      cmp("bank rst", 8'h00, bank);
      s_table();
      s_bank();
      s_freeze();
    end
    final_report();
  end
endmodule
